// [pps_pkg.sv]
package pps_pkg;
    // Register byte addresses on APB
    localparam logic [7:0] PPS_ADDR_OFS = 8'h00;
    localparam logic [7:0] PPS_PINEN_OFS = 8'h04;
    localparam logic [7:0] PPS_STAT_OFS = 8'h08;
    localparam logic [7:0] PPS_PADCFG_OFS = 8'h0C;
    localparam logic [7:0] PPS_MODE_OFS = 8'h10;
    localparam logic [7:0] PPS_OUTA_OFS = 8'h14;
    localparam logic [7:0] PPS_OUTB_OFS = 8'h18;
    localparam logic [7:0] PPS_INA_OFS = 8'h1C;
    localparam logic [7:0] PPS_INB_OFS = 8'h20;
    // Field positions
    localparam int PPS_CS2_BIT = 15;
    localparam int PPS_CS1_BIT = 14;
    localparam int PPS_ADDR_W = 14;
    localparam int PPS_INALL_BIT = 15;
    localparam int PPS_INOVF_BIT = 14;
    localparam int PPS_INSLOT_LSB = 8;
    localparam int PPS_OUTALL_BIT = 7;
    localparam int PPS_OUTUNF_BIT = 6;
    localparam int PPS_OUTSLOT_LSB = 0;
    localparam int PPS_TTL_BIT = 0;
    localparam int PPS_STEP_LSB = 11;
    localparam int PPS_MODE_LSB = 8;
    localparam int PPS_SLOTS = 4;
    // Reset values and the mode write mask
    localparam logic [15:0] PPS_REG_RST = 16'h0000;
    localparam logic [3:0] PPS_OUT_EMPTY_RST = 4'hF;
    localparam logic [15:0] PPS_MODE_MASK = 16'h1F00;

    typedef enum logic [1:0] {
        PPS_MODE_LEGACY,
        PPS_MODE_ADDR_SLAVE,
        PPS_MODE_MASTER_SEP,
        PPS_MODE_MASTER_COMB
    } pps_mode_t;

    typedef enum logic [1:0] {
        PPS_STEP_NONE,
        PPS_STEP_INC,
        PPS_STEP_DEC,
        PPS_STEP_AUTO_BUF
    } pps_step_t;

    // One external byte access as the link side presents it
    typedef struct packed {
        logic wr;
        logic [1:0] slot;
        logic [7:0] data;
    } pps_ext_req_t;

    // Pad functions for the sixteen address pads
    typedef struct packed {
        logic [15:0] func_en;
        logic [15:0] value;
        logic cs2_sel;
        logic cs1_sel;
        logic latch_mode;
    } pps_pads_t;
endpackage

// [pps_port.sv]
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// Function
// - Address register holds a 14-bit target address driven on the pads.
// - Pin-enable bits 15:14 turn top pads into address or chip selects.
// - Pin-enable bits 13:2 turn matching pads into address lines.
// - Pin-enable bits 1:0 turn low pads into address or latch strobes.
// - Input-all-full is one only when every input slot holds data.
// - Per-slot input-full flags set on external write, clear on software read.
// - Output-all-empty is one only when every output slot is empty.
// - Reading an empty output slot sets a sticky underflow flag.
// - Threshold select chooses TTL inputs when one, Schmitt when zero.
// - Host low address bits 00..11 select slots zero to three.
// - Two-bit mode selects legacy, addressable slave, or two master styles.
// - Step mode selects hold, increment, decrement or, in legacy mode only, auto buffer walk.
module pps_port (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External slave-side access, two-entry buffered
    input wire pps_pkg::pps_ext_req_t ext_req,
    input wire logic ext_valid,
    output logic ext_ready,
    output logic [7:0] ext_rdata,
    output logic ext_rvalid,
    input wire logic ext_rready,
    // Master-side transfer step pulse
    input wire logic xfer_done,
    // Pads
    output pps_pkg::pps_pads_t pads,
    output logic ttl_select,
    output pps_pkg::pps_mode_t port_mode
);
    import pps_pkg::*;

    logic [15:0] addr_q, addr_d;
    logic [15:0] pinen_q, pinen_d;
    logic ttl_q, ttl_d;
    logic [15:0] mode_q, mode_d;
    logic [7:0] outb_q [PPS_SLOTS];
    logic [7:0] outb_d [PPS_SLOTS];
    logic [7:0] inb_q [PPS_SLOTS];
    logic [7:0] inb_d [PPS_SLOTS];
    logic [3:0] in_full_q, in_full_d;
    logic [3:0] out_empty_q, out_empty_d;
    logic inovf_q, inovf_d, outunf_q, outunf_d;
    logic [1:0] auto_q, auto_d;
    // Two-entry skid buffer for external requests
    pps_ext_req_t fifo_q [2];
    pps_ext_req_t fifo_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic [7:0] rdat_q, rdat_d;
    logic rval_q, rval_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    pps_pads_t pads_q, pads_d;

    logic acc, wr_en, rd_en, mapped, pop, auto_walk;
    logic rdy_q, rdy_d;
    pps_ext_req_t head;
    logic [1:0] slot;
    pps_mode_t mode;
    pps_step_t step;
    logic [15:0] stat;

    assign mode = pps_mode_t'(mode_q[PPS_MODE_LSB +: 2]);
    assign step = pps_step_t'(mode_q[PPS_STEP_LSB +: 2]);
    assign acc = psel && penable && !pready_q;
    assign wr_en = acc && pwrite;
    assign rd_en = acc && !pwrite;
    assign head = fifo_q[0];
    // Result path stalls the queue, so no word is lost on a slow reader
    assign pop = (cnt_q != 2'd0) && (!rval_q || ext_rready);
    // Legacy auto walk uses its own pointer, others use host bits
    assign auto_walk = (mode == PPS_MODE_LEGACY) &&
        (step == PPS_STEP_AUTO_BUF);
    assign slot = auto_walk ? auto_q : head.slot;
    assign stat = {&in_full_q, inovf_q, 2'b00, in_full_q,
        &out_empty_q, outunf_q, 2'b00, out_empty_q};

    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            PPS_ADDR_OFS, PPS_PINEN_OFS, PPS_STAT_OFS, PPS_PADCFG_OFS,
            PPS_MODE_OFS, PPS_OUTA_OFS, PPS_OUTB_OFS, PPS_INA_OFS,
            PPS_INB_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        addr_d = addr_q;
        pinen_d = pinen_q;
        ttl_d = ttl_q;
        mode_d = mode_q;
        outb_d = outb_q;
        inb_d = inb_q;
        in_full_d = in_full_q;
        out_empty_d = out_empty_q;
        inovf_d = inovf_q;
        outunf_d = outunf_q;
        auto_d = auto_q;
        fifo_d = fifo_q;
        cnt_d = cnt_q;
        rdat_d = rdat_q;
        rval_d = rval_q && !ext_rready;
        prdata_d = prdata_q;
        pready_d = acc;
        pslverr_d = acc && !mapped;
        // Software side first, so hardware sets below win over clears
        if (rd_en) begin
            unique case (paddr)
                PPS_ADDR_OFS: prdata_d = {16'h0000, addr_q};
                PPS_PINEN_OFS: prdata_d = {16'h0000, pinen_q};
                PPS_STAT_OFS: prdata_d = {16'h0000, stat};
                PPS_PADCFG_OFS: prdata_d = {31'h0, ttl_q};
                PPS_MODE_OFS: prdata_d = {16'h0000, mode_q};
                PPS_INA_OFS: begin
                    prdata_d = {16'h0000, inb_q[1], inb_q[0]};
                    in_full_d[1:0] = 2'b00;
                end
                PPS_INB_OFS: begin
                    prdata_d = {16'h0000, inb_q[3], inb_q[2]};
                    in_full_d[3:2] = 2'b00;
                end
                PPS_OUTA_OFS: prdata_d = {16'h0000, outb_q[1], outb_q[0]};
                PPS_OUTB_OFS: prdata_d = {16'h0000, outb_q[3], outb_q[2]};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        if (wr_en) begin
            unique case (paddr)
                PPS_ADDR_OFS: addr_d = pwdata[15:0];
                PPS_PINEN_OFS: pinen_d = pwdata[15:0];
                PPS_PADCFG_OFS: ttl_d = pwdata[PPS_TTL_BIT];
                PPS_MODE_OFS: begin
                    // A new mode starts the buffer walk at slot zero, unless a walking pop in the same cycle loads the old pointer plus one
                    mode_d = pwdata[15:0] & PPS_MODE_MASK;
                    auto_d = 2'd0;
                end
                PPS_STAT_OFS: begin
                    if (!pwdata[PPS_INOVF_BIT]) inovf_d = 1'b0;
                    if (!pwdata[PPS_OUTUNF_BIT]) outunf_d = 1'b0;
                end
                PPS_OUTA_OFS: begin
                    outb_d[0] = pwdata[7:0];
                    outb_d[1] = pwdata[15:8];
                    out_empty_d[1:0] = 2'b00;
                end
                PPS_OUTB_OFS: begin
                    outb_d[2] = pwdata[7:0];
                    outb_d[3] = pwdata[15:8];
                    out_empty_d[3:2] = 2'b00;
                end
                default: ;
            endcase
        end
        // External access from head of the buffer
        if (pop) begin
            if (head.wr) begin
                if (in_full_q[slot]) inovf_d = 1'b1;
                inb_d[slot] = head.data;
                in_full_d[slot] = 1'b1;
            end else begin
                if (out_empty_q[slot]) outunf_d = 1'b1;
                rdat_d = outb_q[slot];
                rval_d = 1'b1;
                out_empty_d[slot] = 1'b1;
            end
            if (auto_walk) auto_d = auto_q + 2'd1;
            fifo_d[0] = fifo_q[1];
        end
        // Master transfers step the address
        if (xfer_done) begin
            unique case (step)
                PPS_STEP_INC: addr_d[PPS_ADDR_W-1:0] =
                    addr_d[PPS_ADDR_W-1:0] + 14'd1;
                PPS_STEP_DEC: addr_d[PPS_ADDR_W-1:0] =
                    addr_d[PPS_ADDR_W-1:0] - 14'd1;
                default: ;
            endcase
        end
        if (ext_valid && ext_ready) begin
            fifo_d[(pop ? cnt_q - 2'd1 : cnt_q) == 2'd0 ? 0 : 1] = ext_req;
        end
        cnt_d = cnt_q + {1'b0, ext_valid && ext_ready} - {1'b0, pop};
        rdy_d = (cnt_d != 2'd2);
        // Pads: enabled pads carry address, top/bottom pairs per pin enable, not per mode
        pads_d.func_en = pinen_q;
        pads_d.value = {addr_q[PPS_CS2_BIT] ? 1'b1 : 1'b0,
            addr_q[PPS_CS1_BIT] ? 1'b1 : 1'b0,
            addr_q[PPS_ADDR_W-1:0]};
        pads_d.cs2_sel = pinen_q[PPS_CS2_BIT] && addr_q[PPS_CS2_BIT];
        pads_d.cs1_sel = pinen_q[PPS_CS1_BIT] && addr_q[PPS_CS1_BIT];
        pads_d.latch_mode = |pinen_q[1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= PPS_REG_RST;
            pinen_q <= PPS_REG_RST;
            ttl_q <= 1'b0;
            mode_q <= PPS_REG_RST;
            for (int i = 0; i < PPS_SLOTS; i++) begin
                outb_q[i] <= 8'h00;
                inb_q[i] <= 8'h00;
            end
            in_full_q <= 4'h0;
            out_empty_q <= PPS_OUT_EMPTY_RST;
            inovf_q <= 1'b0;
            outunf_q <= 1'b0;
            auto_q <= 2'd0;
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
            cnt_q <= 2'd0;
            rdy_q <= 1'b1;
            rdat_q <= 8'h00;
            rval_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            pads_q <= '0;
        end else begin
            addr_q <= addr_d;
            pinen_q <= pinen_d;
            ttl_q <= ttl_d;
            mode_q <= mode_d;
            outb_q <= outb_d;
            inb_q <= inb_d;
            in_full_q <= in_full_d;
            out_empty_q <= out_empty_d;
            inovf_q <= inovf_d;
            outunf_q <= outunf_d;
            auto_q <= auto_d;
            fifo_q <= fifo_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            rdat_q <= rdat_d;
            rval_q <= rval_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            pads_q <= pads_d;
        end
    end

    // Ready only drops when both entries hold, and is a register
    assign ext_ready = rdy_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign ext_rdata = rdat_q;
    assign ext_rvalid = rval_q;
    assign pads = pads_q;
    assign ttl_select = ttl_q;
    assign port_mode = pps_mode_t'(mode_q[PPS_MODE_LSB +: 2]);

    property p_all_full;
        @(posedge pclk) disable iff (!presetn)
        rd_en && paddr == PPS_STAT_OFS
            |=> prdata[PPS_INALL_BIT] == ($past(in_full_q) == 4'hF);
    endproperty
    a_all_full: assert property (p_all_full)
        else $error("input all-full wrong");

    property p_all_empty;
        @(posedge pclk) disable iff (!presetn)
        rd_en && paddr == PPS_STAT_OFS
            |=> prdata[PPS_OUTALL_BIT] == ($past(out_empty_q) == 4'hF);
    endproperty
    a_all_empty: assert property (p_all_empty)
        else $error("output all-empty wrong");

    property p_ovf;
        @(posedge pclk) disable iff (!presetn)
        pop && head.wr && in_full_q[slot] |=> inovf_q;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow not flagged");

    property p_unf;
        @(posedge pclk) disable iff (!presetn)
        pop && !head.wr && out_empty_q[slot] |=> outunf_q;
    endproperty
    a_unf: assert property (p_unf)
        else $error("underflow not flagged");

    property p_infull;
        @(posedge pclk) disable iff (!presetn)
        pop && head.wr |=> in_full_q[$past(slot)];
    endproperty
    a_infull: assert property (p_infull)
        else $error("input slot not full");

    property p_outwr;
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == PPS_OUTA_OFS && !(pop && !head.wr)
            |=> out_empty_q[1:0] == 2'b00;
    endproperty
    a_outwr: assert property (p_outwr)
        else $error("output empty not cleared");

    property p_cs;
        @(posedge pclk) disable iff (!presetn)
        ##1 pads_q.cs2_sel == $past(pinen_q[PPS_CS2_BIT] && addr_q[PPS_CS2_BIT]);
    endproperty
    a_cs: assert property (p_cs)
        else $error("chip select two wrong");

    property p_ttl;
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == PPS_PADCFG_OFS
            |=> ttl_select == $past(pwdata[PPS_TTL_BIT]);
    endproperty
    a_ttl: assert property (p_ttl)
        else $error("threshold select wrong");
endmodule // pps_port

// [pps_host_model.sv]
`timescale 1ns/10ps
module pps_host_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Byte access channel
    output pps_pkg::pps_ext_req_t ext_req,
    output logic ext_valid,
    input wire logic ext_ready,
    input wire logic [7:0] ext_rdata,
    input wire logic ext_rvalid,
    output logic ext_rready
);
    import pps_pkg::*;

    initial begin
        ext_req = '0;
        ext_valid = 1'b0;
        ext_rready = 1'b0;
    end

    // Host takes replies at a random pace, so read data must hold
    always @(posedge pclk) begin
        ext_rready <= presetn && ($urandom % 3 != 0);
    end

    task automatic put(input logic w, input logic [1:0] s,
                       input logic [7:0] d);
        @(posedge pclk);
        ext_req <= {w, s, d};
        ext_valid <= 1'b1;
        do @(posedge pclk); while (ext_ready !== 1'b1);
        ext_valid <= 1'b0;
        // Released lines show no stale request
        ext_req <= ~ext_req;
    endtask
endmodule // pps_host_model

// [parallel_port_addr_status_test.sv]
`timescale 1ns/10ps
module parallel_port_addr_status_test;
    import pps_pkg::*;

    typedef struct {
        logic [31:0] val;
        logic [31:0] mask;
    } pps_note_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pps_ext_req_t ext_req;
    logic ext_valid, ext_ready, ext_rvalid, ext_rready;
    logic [7:0] ext_rdata;
    logic xfer_done = 1'b0;
    pps_pads_t pads;
    logic ttl_select;
    pps_mode_t port_mode;
    int failures = 0;
    int n_compared = 0;
    pps_note_t notes[$];
    logic [15:0] v;
    logic [15:0] u;
    logic [31:0] r;

    always #5 pclk = ~pclk;

    pps_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_req(ext_req), .ext_valid(ext_valid),
        .ext_ready(ext_ready), .ext_rdata(ext_rdata),
        .ext_rvalid(ext_rvalid), .ext_rready(ext_rready),
        .xfer_done(xfer_done), .pads(pads), .ttl_select(ttl_select),
        .port_mode(port_mode));

    pps_host_model host (.pclk(pclk), .presetn(presetn),
        .ext_req(ext_req), .ext_valid(ext_valid), .ext_ready(ext_ready),
        .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid),
        .ext_rready(ext_rready));

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    // Every read answer, bus or host side, meets the oldest note
    always @(posedge pclk) begin
        if ((psel && penable && !pwrite && pready === 1'b1) ||
            (ext_rvalid === 1'b1 && ext_rready)) begin
            r = (psel && penable) ? prdata : {24'h0, ext_rdata};
            if (notes.size() == 0) chk("unexpected answer", 32'h0, r);
            else begin
                chk("answer", notes[0].val & notes[0].mask,
                    r & notes[0].mask);
                void'(notes.pop_front());
            end
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF);
        notes.push_back('{e, m});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic hrd(input logic [1:0] s, input logic [7:0] e,
                       input logic [31:0] m = 32'hFF);
        notes.push_back('{{24'h0, e}, m});
        host.put(1'b0, s, 8'h00);
        for (int i = 0; i < 40 && notes.size() != 0; i++) @(posedge pclk);
    endtask

    task automatic step(input logic [15:0] m, input logic [13:0] e);
        apb(1'b1, PPS_MODE_OFS, {16'h0, m});
        @(posedge pclk) xfer_done <= 1'b1;
        @(posedge pclk) xfer_done <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(PPS_ADDR_OFS, {18'h0, e}, 32'h3FFF);
    endtask

    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        give_verdict();
    end

    initial begin
        void'($urandom(84));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(PPS_STAT_OFS, 32'h008F);
        rd(PPS_PADCFG_OFS, 32'h0000);
        $display("Reset values done");
        v = 16'($urandom);
        u = 16'($urandom);
        apb(1'b1, PPS_PINEN_OFS, {16'h0, u});
        rd(PPS_PINEN_OFS, {16'h0, u});
        apb(1'b1, PPS_ADDR_OFS, {16'h0, v});
        rd(PPS_ADDR_OFS, {16'h0, v});
        chk("pad enables", u, pads.func_en);
        chk("pad value", v, pads.value);
        chk("cs2", v[15] & u[15], pads.cs2_sel);
        chk("cs1", v[14] & u[14], pads.cs1_sel);
        chk("latch", |u[1:0], pads.latch_mode);
        // Pads are registered one edge behind the address register
        apb(1'b1, PPS_PINEN_OFS, 32'hC000);
        apb(1'b1, PPS_ADDR_OFS, 32'hC000);
        @(posedge pclk);
        chk("cs2 on", 1'b1, pads.cs2_sel);
        chk("cs1 on", 1'b1, pads.cs1_sel);
        apb(1'b1, PPS_PADCFG_OFS, 32'h1);
        chk("threshold", 1'b1, ttl_select);
        rd(PPS_PADCFG_OFS, 32'h0001);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, PPS_MODE_OFS, 32'(m) << PPS_MODE_LSB);
            chk("mode", 32'(m), 32'(port_mode));
        end
        apb(1'b1, PPS_ADDR_OFS, 32'h0010);
        step(16'h0A00, 14'h0011);
        step(16'h1200, 14'h0010);
        step(16'h0200, 14'h0010);
        notes.push_back('{32'h0, 32'hFFFFFFFF});
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 1'b1, pslverr);
        $display("Register tests done");
        apb(1'b1, PPS_MODE_OFS, 32'h0100);
        for (int s = 0; s < 4; s++) host.put(1'b1, 2'(s), 8'hA0 + 8'(s));
        repeat (4) @(posedge pclk);
        rd(PPS_STAT_OFS, 32'h8F8F);
        rd(PPS_INA_OFS, 32'hA1A0);
        rd(PPS_INB_OFS, 32'hA3A2);
        rd(PPS_STAT_OFS, 32'h008F);
        host.put(1'b1, 2'd2, 8'h5C);
        host.put(1'b1, 2'd2, 8'h5D);
        repeat (4) @(posedge pclk);
        rd(PPS_STAT_OFS, 32'h448F);
        apb(1'b1, PPS_STAT_OFS, 32'h0);
        rd(PPS_STAT_OFS, 32'h048F);
        rd(PPS_INB_OFS, 32'hA300, 32'hFF00);
        $display("Input buffer tests done");
        apb(1'b1, PPS_OUTA_OFS, 32'hBBAA);
        rd(PPS_STAT_OFS, 32'h000C);
        hrd(2'd0, 8'hAA);
        hrd(2'd1, 8'hBB);
        rd(PPS_STAT_OFS, 32'h008F);
        hrd(2'd0, 8'h00, 32'h0);
        rd(PPS_STAT_OFS, 32'h00CF);
        $display("Output buffer tests done");
        // Legacy walk ignores the host slot bits
        apb(1'b1, PPS_MODE_OFS, 32'h1800);
        for (int s = 0; s < 4; s++) host.put(1'b1, 2'd3, 8'hC0 + 8'(s));
        repeat (4) @(posedge pclk);
        rd(PPS_INA_OFS, 32'hC1C0);
        rd(PPS_INB_OFS, 32'hC3C2);
        $display("Auto walk tests done");
        give_verdict();
    end
endmodule // parallel_port_addr_status_test
